// File: hw/eec_pkg.sv
// Package for the E1 error counter and interrupt status block.
// Assumes an 8-bit processor port with a 5-bit register address.
package eec_pkg;

  // Register port and counter widths
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 16;

  // Register offsets within the status page
  localparam logic [4:0] OFS_LCV_HIGH   = 5'h16;
  localparam logic [4:0] OFS_LCV_LOW    = 5'h17;
  localparam logic [4:0] OFS_CRC_HIGH   = 5'h18;
  localparam logic [4:0] OFS_CRC_LOW    = 5'h19;
  localparam logic [4:0] OFS_SYNC_IRQ   = 5'h1b;
  localparam logic [4:0] OFS_ERROR_IRQ  = 5'h1c;

  // Reset values and the one-count step
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [15:0] COUNT_ZERO    = 16'h0000;
  localparam logic [15:0] COUNT_ONE     = 16'h0001;

  // Sync and alarm status word bit positions
  localparam int unsigned BIT_FRAME_SYNC_CHG  = 7;
  localparam int unsigned BIT_MFRAME_SYNC_CHG = 6;
  localparam int unsigned BIT_CRC_SYNC_CHG    = 5;
  localparam int unsigned BIT_ALL_ONES_CHG    = 4;
  localparam int unsigned BIT_SIGNAL_LOSS     = 3;
  localparam int unsigned BIT_CONSEC_FAS_ERR  = 2;
  localparam int unsigned BIT_MFRAME_LOSS     = 1;
  localparam int unsigned BIT_ELASTIC_SLIP    = 0;

  // Error event status word bit positions
  localparam int unsigned BIT_FAS_BIT_ERR     = 7;
  localparam int unsigned BIT_LOCAL_CRC_ERR   = 6;
  localparam int unsigned BIT_FAR_END_ERR     = 5;
  localparam int unsigned BIT_SLOT16_ONES     = 4;
  localparam int unsigned BIT_CODE_VIOLATION  = 3;
  localparam int unsigned BIT_TEST_PATTERN    = 2;
  localparam int unsigned BIT_AUX_PATTERN     = 1;
  localparam int unsigned BIT_REMOTE_ALARM    = 0;

  // Alternating auxiliary pattern run length in bits
  localparam int unsigned AUX_RUN_LEN = 512;
  localparam int unsigned AUX_RUN_W   = 10;

endpackage

// File: hw/eec_err_counter.sv
// Wrapping event counter with a registered overflow pulse.
// Assumes the event input is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
module eec_err_counter #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  input  wire logic             event_in,
  output logic [WIDTH-1:0]      count_out,
  output logic                  overflow_out
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             overflow_reg;
  logic             wrap_now;

  // All ones rolls over to zero; the rollover is the overflow event
  assign wrap_now   = event_in && (&count_reg);
  assign count_next = event_in ? count_reg + {{(WIDTH-1){1'b0}}, 1'b1} : count_reg;

  // Counter and overflow flag
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      count_reg    <= '0;
      overflow_reg <= 1'b0;
    end else begin
      count_reg    <= count_next;
      overflow_reg <= wrap_now;
    end
  end

  assign count_out    = count_reg;
  assign overflow_out = overflow_reg;

endmodule

// File: hw/eec_status_top.sv
// E1 receive error counters and read-to-clear interrupt status words.
// Assumes framer events arrive on core_clk_in as one-cycle pulses or
// levels, and the processor port is already synchronous to that clock.
//
// Functional notes
// - Sixteen-bit code violation count, high byte at 16h, low byte at 17h.
// - Excess-zero select low: count only non-substitution bipolar violations.
// - Excess-zero select high: also count excess consecutive zero events.
// - Sixteen-bit CRC-4 error count, high byte at 18h, low byte at 19h.
// - Reading either status word at 1Bh or 1Ch clears its bits.
// - Sync word bit 7 sets on any change of frame sync.
// - Sync word bit 6 sets on any change of multiframe sync.
// - Sync word bit 5 sets on any change of CRC-4 sync.
// - Sync word bit 4 sets on any change of all-ones alarm.
// - Sync word bit 3 sets while analog or digital signal loss exists.
// - Sync word bit 2 sets when the last two alignment words errored.
// - Sync word bit 1 sets when multiframe alignment is lost.
// - Sync word bit 0 sets on a controlled elastic buffer slip.
// - Error word bit 7 sets on alignment bit error while frame synced.
// - Error word bit 6 sets on a local CRC-4 failure.
// - Error word bit 5 sets on a wrong E-bit in a multiframe.
// - Error word bit 4 sets when time slot 16 carries all ones.
// - Error word bit 3 sets on any non-substitution code violation.
// - Error word bit 2 sets on a bit error in a PRBS channel.
// - Error word bit 1 sets after 512 bits of alternating pattern.
// - Error word bit 0 sets when received remote alarm bit is one.
// - Mask bit one enables its status bit, zero suppresses it.
// - Counters wrap from all ones to zero, reported as overflow.
`timescale 1ns/100ps
module eec_status_top
  import eec_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              reset_in,
  // Processor port
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              read_strobe_in,
  output logic [DATA_W-1:0]      read_data_out,
  // Control
  input  wire logic              excess_zero_counting_select_in,
  input  wire logic [7:0]        sync_alarm_irq_mask_in,
  input  wire logic [7:0]        error_event_irq_mask_in,
  // Framer conditions (levels)
  input  wire logic              frame_sync_in,
  input  wire logic              multiframe_sync_in,
  input  wire logic              checksum_sync_in,
  input  wire logic              all_ones_in,
  input  wire logic              signal_loss_in,
  input  wire logic              slot16_all_ones_in,
  // Framer events (one-cycle pulses)
  input  wire logic              fas_checked_in,
  input  wire logic              fas_errored_in,
  input  wire logic              multiframe_loss_in,
  input  wire logic              elastic_slip_in,
  input  wire logic              local_checksum_error_in,
  input  wire logic              far_end_block_error_in,
  input  wire logic              bipolar_violation_in,
  input  wire logic              excess_zeros_in,
  input  wire logic              test_pattern_error_in,
  input  wire logic              nfas_valid_in,
  input  wire logic              nfas_bit3_in,
  // Received bit stream for the auxiliary pattern
  input  wire logic              rx_bit_valid_in,
  input  wire logic              rx_bit_in,
  // Counter overflow events
  output logic                   code_violation_overflow_out,
  output logic                   checksum_error_overflow_out
);

  // Single decode used by both the read mux and the clear logic
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs,
                                    input logic              rd);
    addr_hit = rd && (a == ofs);
  endfunction

  localparam logic [AUX_RUN_W-1:0] AUX_RUN_FULL = AUX_RUN_W'(AUX_RUN_LEN);
  localparam logic [AUX_RUN_W-1:0] AUX_RUN_ONE  = AUX_RUN_W'(1);

  logic [CNT_W-1:0]     lcv_count;
  logic [CNT_W-1:0]     crc_count;
  logic                 lcv_event;
  logic [7:0]           sync_status_reg;
  logic [7:0]           sync_status_next;
  logic [7:0]           error_status_reg;
  logic [7:0]           error_status_next;
  logic [7:0]           sync_set;
  logic [7:0]           error_set;
  logic [7:0]           sync_raw;
  logic [7:0]           error_raw;
  logic                 sync_read;
  logic                 error_read;
  logic [DATA_W-1:0]    read_data_reg;
  logic [DATA_W-1:0]    read_data_next;
  logic                 frame_sync_reg;
  logic                 multiframe_sync_reg;
  logic                 checksum_sync_reg;
  logic                 all_ones_reg;
  logic                 fas_prev_err_reg;
  logic                 prev_bit_reg;
  logic [AUX_RUN_W-1:0] aux_run_reg;
  logic [AUX_RUN_W-1:0] aux_run_next;
  logic                 aux_hit;

  // Violation qualification; excess zeros only count when selected
  assign lcv_event = bipolar_violation_in ||
                     (excess_zero_counting_select_in && excess_zeros_in);

  // Line code violation counter
  eec_err_counter #(
    .WIDTH        (CNT_W)
  ) u_line_violation_count_high (
    .core_clk_in  (core_clk_in),
    .reset_in     (reset_in),
    .event_in     (lcv_event),
    .count_out    (lcv_count),
    .overflow_out (code_violation_overflow_out)
  );

  // CRC-4 error counter
  eec_err_counter #(
    .WIDTH        (CNT_W)
  ) u_crc_counter (
    .core_clk_in  (core_clk_in),
    .reset_in     (reset_in),
    .event_in     (local_checksum_error_in),
    .count_out    (crc_count),
    .overflow_out (checksum_error_overflow_out)
  );

  // Previous condition levels for change detection
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      frame_sync_reg      <= 1'b0;
      multiframe_sync_reg <= 1'b0;
      checksum_sync_reg   <= 1'b0;
      all_ones_reg        <= 1'b0;
    end else begin
      frame_sync_reg      <= frame_sync_in;
      multiframe_sync_reg <= multiframe_sync_in;
      checksum_sync_reg   <= checksum_sync_in;
      all_ones_reg        <= all_ones_in;
    end
  end

  // Error state of the previous alignment word
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      fas_prev_err_reg <= 1'b0;
    end else if (fas_checked_in) begin
      fas_prev_err_reg <= fas_errored_in;
    end
  end

  // Alternating run length; a repeated bit restarts the run at one
  assign aux_run_next = !rx_bit_valid_in             ? aux_run_reg :
                        (rx_bit_in == prev_bit_reg)  ? AUX_RUN_ONE :
                        (aux_run_reg == AUX_RUN_FULL) ? aux_run_reg :
                        aux_run_reg + AUX_RUN_ONE;
  assign aux_hit = (aux_run_next == AUX_RUN_FULL) && (aux_run_reg != AUX_RUN_FULL);

  // Run tracker; saturates so a long pattern reports only once
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      aux_run_reg  <= '0;
      prev_bit_reg <= 1'b0;
    end else if (rx_bit_valid_in) begin
      aux_run_reg  <= aux_run_next;
      prev_bit_reg <= rx_bit_in;
    end
  end

  // Raw sync and alarm sources before masking
  assign sync_raw[BIT_FRAME_SYNC_CHG]  = frame_sync_in != frame_sync_reg;
  assign sync_raw[BIT_MFRAME_SYNC_CHG] = multiframe_sync_in != multiframe_sync_reg;
  assign sync_raw[BIT_CRC_SYNC_CHG]    = checksum_sync_in != checksum_sync_reg;
  assign sync_raw[BIT_ALL_ONES_CHG]    = all_ones_in != all_ones_reg;
  assign sync_raw[BIT_SIGNAL_LOSS]     = signal_loss_in;
  assign sync_raw[BIT_CONSEC_FAS_ERR]  = fas_checked_in && fas_errored_in &&
                                         fas_prev_err_reg;
  assign sync_raw[BIT_MFRAME_LOSS]     = multiframe_loss_in;
  assign sync_raw[BIT_ELASTIC_SLIP]    = elastic_slip_in;

  // Raw error event sources before masking
  assign error_raw[BIT_FAS_BIT_ERR]    = fas_checked_in && fas_errored_in &&
                                         frame_sync_in;
  assign error_raw[BIT_LOCAL_CRC_ERR]  = local_checksum_error_in;
  assign error_raw[BIT_FAR_END_ERR]    = far_end_block_error_in;
  assign error_raw[BIT_SLOT16_ONES]    = slot16_all_ones_in;
  assign error_raw[BIT_CODE_VIOLATION] = bipolar_violation_in;
  assign error_raw[BIT_TEST_PATTERN]   = test_pattern_error_in;
  assign error_raw[BIT_AUX_PATTERN]    = aux_hit;
  assign error_raw[BIT_REMOTE_ALARM]   = nfas_valid_in && nfas_bit3_in;

  // Mask gates each source; one enables
  assign sync_set  = sync_raw & sync_alarm_irq_mask_in;
  assign error_set = error_raw & error_event_irq_mask_in;

  // Read decode for clearing
  assign sync_read  = addr_hit(addr_in, OFS_SYNC_IRQ, read_strobe_in);
  assign error_read = addr_hit(addr_in, OFS_ERROR_IRQ, read_strobe_in);

  // Read clears the word; a set in the same cycle survives the clear
  assign sync_status_next  = (sync_read ? BYTE_ZERO : sync_status_reg) | sync_set;
  assign error_status_next = (error_read ? BYTE_ZERO : error_status_reg) | error_set;

  // Status words
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sync_status_reg  <= BYTE_ZERO;
      error_status_reg <= BYTE_ZERO;
    end else begin
      sync_status_reg  <= sync_status_next;
      error_status_reg <= error_status_next;
    end
  end

  // Read mux; unmapped offsets read as zero
  assign read_data_next =
    addr_hit(addr_in, OFS_LCV_HIGH, read_strobe_in)  ? lcv_count[15:8]  :
    addr_hit(addr_in, OFS_LCV_LOW, read_strobe_in)   ? lcv_count[7:0]   :
    addr_hit(addr_in, OFS_CRC_HIGH, read_strobe_in)  ? crc_count[15:8]  :
    addr_hit(addr_in, OFS_CRC_LOW, read_strobe_in)   ? crc_count[7:0]   :
    sync_read                                        ? sync_status_reg  :
    error_read                                       ? error_status_reg :
    read_data_reg;

  // Read data holds until the next read strobe
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      read_data_reg <= BYTE_ZERO;
    end else if (read_strobe_in) begin
      read_data_reg <= addr_hit(addr_in, OFS_SYNC_IRQ, 1'b1) ||
                       addr_hit(addr_in, OFS_ERROR_IRQ, 1'b1) ||
                       addr_hit(addr_in, OFS_LCV_HIGH, 1'b1) ||
                       addr_hit(addr_in, OFS_LCV_LOW, 1'b1) ||
                       addr_hit(addr_in, OFS_CRC_HIGH, 1'b1) ||
                       addr_hit(addr_in, OFS_CRC_LOW, 1'b1) ? read_data_next : BYTE_ZERO;
    end
  end

  assign read_data_out = read_data_reg;

  // Checks on counters, masking and read-to-clear
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  a_lcv_increment: assert property (
    lcv_event |=> lcv_count == $past(lcv_count) + COUNT_ONE)
    else $error("code violation count did not advance");

  a_lcv_exz_off: assert property (
    !excess_zero_counting_select_in && excess_zeros_in && !bipolar_violation_in
    |=> $stable(lcv_count))
    else $error("excess zeros counted while not selected");

  a_lcv_exz_on: assert property (
    excess_zero_counting_select_in && excess_zeros_in
    |=> lcv_count == $past(lcv_count) + COUNT_ONE)
    else $error("excess zeros not counted while selected");

  a_crc_increment: assert property (
    local_checksum_error_in |=> crc_count == $past(crc_count) + COUNT_ONE)
    else $error("CRC error count did not advance");

  a_lcv_high_read: assert property (
    read_strobe_in && addr_in == OFS_LCV_HIGH |=> read_data_out == $past(lcv_count[15:8]))
    else $error("high count byte read wrong");

  a_crc_low_read: assert property (
    read_strobe_in && addr_in == OFS_CRC_LOW |=> read_data_out == $past(crc_count[7:0]))
    else $error("low CRC byte read wrong");

  a_sync_read_clear: assert property (
    sync_read |=> sync_status_reg == $past(sync_set) &&
                  read_data_out == $past(sync_status_reg))
    else $error("sync word not returned and cleared on read");

  a_error_read_clear: assert property (
    error_read |=> error_status_reg == $past(error_set))
    else $error("error word not cleared on read");

  a_fsync_change: assert property (
    $changed(frame_sync_in) && sync_alarm_irq_mask_in[BIT_FRAME_SYNC_CHG]
    |=> sync_status_reg[BIT_FRAME_SYNC_CHG])
    else $error("frame sync change not flagged");

  // Checker's own memory of the last checked word; any spacing between checks
  logic chk_fas_err_reg;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      chk_fas_err_reg <= 1'b0;
    end else if (fas_checked_in) begin
      chk_fas_err_reg <= fas_errored_in;
    end
  end

  a_consec_fas: assert property (
    fas_checked_in && fas_errored_in && chk_fas_err_reg &&
    sync_alarm_irq_mask_in[BIT_CONSEC_FAS_ERR]
    |=> sync_status_reg[BIT_CONSEC_FAS_ERR])
    else $error("two errored alignment words not flagged");

  a_consec_pair: assert property (
    $rose(sync_status_reg[BIT_CONSEC_FAS_ERR])
    |-> $past(fas_checked_in && fas_errored_in && chk_fas_err_reg))
    else $error("alignment pair flagged without two errored words");

  a_fas_needs_sync: assert property (
    $rose(error_status_reg[BIT_FAS_BIT_ERR]) |-> $past(frame_sync_in))
    else $error("alignment bit error flagged without frame sync");

  a_mask_blocks: assert property (
    $rose(sync_status_reg[BIT_SIGNAL_LOSS])
    |-> $past(sync_alarm_irq_mask_in[BIT_SIGNAL_LOSS]))
    else $error("masked signal loss reached status");

  a_lcv_wrap: assert property (
    lcv_event && lcv_count == 16'hffff
    |=> lcv_count == COUNT_ZERO && code_violation_overflow_out)
    else $error("counter wrap not reported");

  a_aux_run: assert property (
    $rose(error_status_reg[BIT_AUX_PATTERN]) |-> $past(aux_run_next) == AUX_RUN_FULL)
    else $error("auxiliary pattern flagged before full run");

  a_status_hold: assert property (
    !sync_read |=> (sync_status_reg & $past(sync_status_reg)) == $past(sync_status_reg))
    else $error("sync word bit lost without a read");

  a_remote_alarm: assert property (
    nfas_valid_in && nfas_bit3_in && error_event_irq_mask_in[BIT_REMOTE_ALARM]
    |=> error_status_reg[BIT_REMOTE_ALARM])
    else $error("remote alarm not flagged");

  a_error_mask: assert property (
    $rose(error_status_reg[BIT_CODE_VIOLATION])
    |-> $past(error_event_irq_mask_in[BIT_CODE_VIOLATION]))
    else $error("masked code violation reached status");

  a_crc_wrap: assert property (
    local_checksum_error_in && (&crc_count)
    |=> crc_count == COUNT_ZERO && checksum_error_overflow_out)
    else $error("CRC counter wrap not reported");

  c_sync_read: cover property (sync_read && sync_status_reg != BYTE_ZERO);
  c_set_on_clear: cover property (error_read && error_set != BYTE_ZERO);
  c_lcv_wrap: cover property (code_violation_overflow_out);
  c_aux_seen: cover property (aux_hit);
  c_alarm_clear: cover property (nfas_valid_in && !nfas_bit3_in);

endmodule

// File: testbench/eec_line_model.sv
// Behavioural model of the receive line as the framer reports it.
// Assumes the block samples every event and level on core_clk_in rising edges.
`timescale 1ns/100ps
module eec_line_model (
  input  wire logic        core_clk_in,
  output logic [13:0]      ev_out,
  output logic             fas_checked_out,
  output logic             fas_errored_out,
  output logic             rx_bit_valid_out,
  output logic             rx_bit_out
);
  // Idle lines show misleading values so unqualified sampling is caught
  initial begin
    ev_out           = 14'h0000;
    fas_checked_out  = 1'b0;
    fas_errored_out  = 1'b1;
    rx_bit_valid_out = 1'b0;
    rx_bit_out       = 1'b0;
  end

  // Raise or drop a group of condition and event lines after an edge
  task automatic level(input logic [13:0] m, input logic v);
    @(posedge core_clk_in);
    #1;
    ev_out = v ? (ev_out | m) : (ev_out & ~m);
  endtask

  // Hold a group high for exactly n sampling edges
  task automatic burst(input logic [13:0] m, input int n);
    level(m, 1'b1);
    repeat (n - 1) @(posedge core_clk_in);
    level(m, 1'b0);
  endtask

  // One checked alignment word; the error flag only counts beside the check
  task automatic fas_check(input logic err);
    @(posedge core_clk_in);
    #1;
    fas_checked_out = 1'b1;
    fas_errored_out = err;
    @(posedge core_clk_in);
    #1;
    fas_checked_out = 1'b0;
    fas_errored_out = ~err;
  endtask

  // Alternating bit run, one valid bit per cycle, starting with first
  task automatic aux_bits(input int n, input logic first);
    logic b;
    b = first;
    repeat (n) begin
      @(posedge core_clk_in);
      #1;
      rx_bit_valid_out = 1'b1;
      rx_bit_out       = b;
      b                = ~b;
    end
    @(posedge core_clk_in);
    #1;
    rx_bit_valid_out = 1'b0;
    rx_bit_out       = ~rx_bit_out;
  endtask
endmodule

// File: testbench/e1_error_count_irq_status_tb.sv
// Self-checking bench for the error counters and read-to-clear status words.
// Assumes the line model drives every framer input except nfas_bit3_in, which the bench drives; reads use the 5-bit port.
`timescale 1ns/100ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module e1_error_count_irq_status_tb;
  import eec_pkg::*;
  logic              clk       = 1'b0;
  logic              rst       = 1'b1;
  logic [ADDR_W-1:0] addr      = 5'h00;
  logic              strobe    = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              sel       = 1'b0;
  logic              nfas_b3   = 1'b1;
  logic [7:0]        mask_s    = 8'hff;
  logic [7:0]        mask_e    = 8'hff;
  logic [13:0]       ev;
  logic              fas_chk;
  logic              fas_err;
  logic              rxv;
  logic              rxb;
  logic              ovf_l;
  logic              ovf_c;
  int                n_fail    = 0;
  int                checked   = 0;
  int                n_ovf_l   = 0;
  int                n_ovf_c   = 0;
  // Ordinary sources: row i fires line i, then the word and bit it must set
  logic [4:0]        row_addr [13] = '{5'h1b, 5'h1b, 5'h1c, 5'h1c, 5'h1c, 5'h1c, 5'h1c,
                                      5'h1b, 5'h1b, 5'h1b, 5'h1b, 5'h1b, 5'h1c};
  logic [7:0]        row_exp  [13] = '{8'h02, 8'h01, 8'h40, 8'h20, 8'h08, 8'h04, 8'h01,
                                      8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h10};

  initial begin
    forever #5 clk = ~clk;
  end

  eec_line_model i_line (
    .core_clk_in      (clk),
    .ev_out           (ev),
    .fas_checked_out  (fas_chk),
    .fas_errored_out  (fas_err),
    .rx_bit_valid_out (rxv),
    .rx_bit_out       (rxb)
  );

  eec_status_top i_dut (
    .core_clk_in                    (clk),
    .reset_in                       (rst),
    .addr_in                        (addr),
    .read_strobe_in                 (strobe),
    .read_data_out                  (rdata),
    .excess_zero_counting_select_in (sel),
    .sync_alarm_irq_mask_in         (mask_s),
    .error_event_irq_mask_in        (mask_e),
    .frame_sync_in                  (ev[7]),
    .multiframe_sync_in             (ev[8]),
    .checksum_sync_in               (ev[9]),
    .all_ones_in                    (ev[10]),
    .signal_loss_in                 (ev[11]),
    .slot16_all_ones_in             (ev[12]),
    .fas_checked_in                 (fas_chk),
    .fas_errored_in                 (fas_err),
    .multiframe_loss_in             (ev[0]),
    .elastic_slip_in                (ev[1]),
    .local_checksum_error_in        (ev[2]),
    .far_end_block_error_in         (ev[3]),
    .bipolar_violation_in           (ev[4]),
    .excess_zeros_in                (ev[13]),
    .test_pattern_error_in          (ev[5]),
    .nfas_valid_in                  (ev[6]),
    .nfas_bit3_in                   (nfas_b3),
    .rx_bit_valid_in                (rxv),
    .rx_bit_in                      (rxb),
    .code_violation_overflow_out    (ovf_l),
    .checksum_error_overflow_out    (ovf_c)
  );

  // Overflow pulses are one cycle wide, so count every edge they are seen
  always @(posedge clk) begin
    if (ovf_l === 1'b1) n_ovf_l++;
    if (ovf_c === 1'b1) n_ovf_c++;
  end

  // One read: strobe for one edge, data is settled after the next edge
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    addr   = a;
    strobe = 1'b1;
    @(posedge clk);
    #1;
    strobe = 1'b0;
    `CHK(rdata, exp)
  endtask

  task automatic counts(input logic [15:0] lcv, input logic [15:0] crc);
    rd_chk(OFS_LCV_HIGH, lcv[15:8]);
    rd_chk(OFS_LCV_LOW, lcv[7:0]);
    rd_chk(OFS_CRC_HIGH, crc[15:8]);
    rd_chk(OFS_CRC_LOW, crc[7:0]);
  endtask

  task automatic conclude();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Guard against a hang; the full run needs roughly 67k cycles
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    conclude();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    // Everything reads zero after reset, unmapped offset included
    counts(16'h0000, 16'h0000);
    rd_chk(OFS_SYNC_IRQ, 8'h00);
    rd_chk(OFS_ERROR_IRQ, 8'h00);
    rd_chk(5'h1a, 8'h00);
    $display("test reset done");
    // Each source sets its own bit once, and the read clears it
    for (int i = 0; i < 13; i++) begin
      i_line.burst(14'h0001 << i, 1);
      repeat (2) @(posedge clk);
      rd_chk(row_addr[i], row_exp[i]);
      rd_chk(row_addr[i], 8'h00);
    end
    // Remote alarm bit low: a valid word must not flag
    nfas_b3 = 1'b0;
    i_line.burst(14'h0040, 1);
    repeat (2) @(posedge clk);
    rd_chk(OFS_ERROR_IRQ, 8'h00);
    nfas_b3 = 1'b1;
    $display("test sources done");
    // Back-to-back violations and the excess-zero select
    i_line.burst(14'h0010, 3);
    i_line.burst(14'h2000, 3);
    counts(16'h0004, 16'h0001);
    sel = 1'b1;
    i_line.burst(14'h2000, 2);
    i_line.burst(14'h2010, 2);
    i_line.burst(14'h0004, 2);
    counts(16'h0008, 16'h0003);
    rd_chk(OFS_ERROR_IRQ, 8'h48);
    $display("test counters done");
    // Masked sources leave nothing set and nothing pending
    mask_s = 8'h00;
    mask_e = 8'h00;
    i_line.burst(14'h1fff, 1);
    repeat (3) @(posedge clk);
    rd_chk(OFS_SYNC_IRQ, 8'h00);
    rd_chk(OFS_ERROR_IRQ, 8'h00);
    mask_s = 8'hff;
    mask_e = 8'hff;
    repeat (2) @(posedge clk);
    rd_chk(OFS_SYNC_IRQ, 8'h00);
    rd_chk(OFS_ERROR_IRQ, 8'h00);
    $display("test masks done");
    // Alignment errors: pairing, and the bit error only while in sync
    i_line.fas_check(1'b1);
    i_line.fas_check(1'b1);
    repeat (2) @(posedge clk);
    rd_chk(OFS_SYNC_IRQ, 8'h04);
    rd_chk(OFS_ERROR_IRQ, 8'h00);
    i_line.fas_check(1'b0);
    i_line.fas_check(1'b1);
    repeat (2) @(posedge clk);
    rd_chk(OFS_SYNC_IRQ, 8'h00);
    i_line.level(14'h0080, 1'b1);
    repeat (2) @(posedge clk);
    rd_chk(OFS_SYNC_IRQ, 8'h80);
    i_line.fas_check(1'b1);
    repeat (2) @(posedge clk);
    rd_chk(OFS_ERROR_IRQ, 8'h80);
    rd_chk(OFS_SYNC_IRQ, 8'h04);
    i_line.level(14'h0080, 1'b0);
    repeat (2) @(posedge clk);
    rd_chk(OFS_SYNC_IRQ, 8'h80);
    $display("test alignment done");
    // Alternating run: broken run, one short, exact length, then no repeat
    i_line.aux_bits(300, 1'b1);
    i_line.aux_bits(300, 1'b0);
    i_line.aux_bits(511, 1'b1);
    rd_chk(OFS_ERROR_IRQ, 8'h00);
    i_line.aux_bits(1, 1'b0);
    repeat (2) @(posedge clk);
    rd_chk(OFS_ERROR_IRQ, 8'h02);
    i_line.aux_bits(20, 1'b1);
    rd_chk(OFS_ERROR_IRQ, 8'h00);
    $display("test pattern done");
    // Full wrap of both counters: one overflow each, counts come back
    `CHK(n_ovf_l, 0)
    i_line.burst(14'h0014, 65536);
    repeat (2) @(posedge clk);
    `CHK(n_ovf_l, 1)
    `CHK(n_ovf_c, 1)
    // Masks gate status only, so the masked burst counted one of each
    counts(16'h0009, 16'h0004);
    rd_chk(OFS_ERROR_IRQ, 8'h48);
    $display("test overflow done");
    conclude();
  end
endmodule
